//--- verilog/rxfe_top.v
// Receive error handling, frame check seed and header format control with register bus
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rxfe_map.vh"

module rxfe_top
(
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Receive datapath events
  input  wire        rx_frame_start,
  input  wire        rx_hdr_valid,
  input  wire [9:0]  rx_hdr_len,
  input  wire        rx_byte_valid,
  input  wire [7:0]  rx_byte,
  input  wire        rx_rs_error,
  // Receive control outputs
  output reg         rx_on,
  output reg         rx_hunt_start,
  output reg         rx_abort,
  output reg         rx_frame_done,
  output reg         rx_fcs_ok,
  // Transmit check sequence
  input  wire        tx_start,
  input  wire        tx_byte_valid,
  input  wire [7:0]  tx_byte,
  input  wire        tx_last,
  output wire [15:0] tx_fcs,
  output reg         tx_fcs_done
);

  // Receive states
  localparam [1:0] ST_OFF  = 2'd0;
  localparam [1:0] ST_HUNT = 2'd1;
  localparam [1:0] ST_HDR  = 2'd2;
  localparam [1:0] ST_DATA = 2'd3;

  // Configuration bits
  reg        rs_error_abort_disable;
  reg        rx_auto_reenable;
  reg        fcs_seed_all_ones;
  reg        header_format_select;
  // Event flags
  reg        rx_rs_decode_error_flag;
  reg        flag_good;
  reg        flag_fcs_err;
  reg        flag_len_err;
  // Receive machine
  reg  [1:0] state;
  reg  [1:0] next_state;
  reg  [9:0] frame_len;
  reg  [9:0] byte_cnt;
  reg        check_pend;
  // Bus slave holding
  reg        aw_held;
  reg        w_held;
  reg  [3:0] aw_addr;
  reg [31:0] w_data;
  reg  [3:0] w_strb;
  // Decode and event wires
  wire [15:0] rx_crc;
  wire [9:0]  hdr_len;
  wire        hdr_bad;
  wire        wr_do;
  wire        rx_cmd_on;
  wire        rx_cmd_off;
  wire        rs_hit;
  wire        rs_abort;
  wire        last_byte;
  wire        hdr_fail;
  wire        ev_clr_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Check sequence units for receive and transmit
  rxfe_fcs u_rx_fcs
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .init       (state == ST_HUNT && rx_frame_start),
    .seed_ones  (fcs_seed_all_ones),
    .byte_valid (state == ST_DATA && rx_byte_valid),
    .byte_data  (rx_byte),
    .crc        (rx_crc)
  );

  rxfe_fcs u_tx_fcs
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .init       (tx_start),
    .seed_ones  (fcs_seed_all_ones),
    .byte_valid (tx_byte_valid),
    .byte_data  (tx_byte),
    .crc        (tx_fcs)
  );

  // Header length check
  rxfe_hdr_check u_hdr
  (
    .hdr_len_raw    (rx_hdr_len),
    .hdr_format_ext (header_format_select),
    .frame_len      (hdr_len),
    .len_bad        (hdr_bad)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes: one write and one read at a time
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_do         = aw_held && w_held && !s_axi_bvalid;

  // Software commands and event clear
  assign rx_cmd_on  = wr_do && aw_addr == `RXFE_OFF_CTRL && w_strb[1] &&
                      w_data[`RXFE_CTRL_RX_ON_CMD];
  assign rx_cmd_off = wr_do && aw_addr == `RXFE_OFF_CTRL && w_strb[1] &&
                      w_data[`RXFE_CTRL_RX_OFF_CMD];
  assign ev_clr_wr  = wr_do && aw_addr == `RXFE_OFF_EVENT && w_strb[0];

  // Receive events
  assign rs_hit    = (state == ST_HDR || state == ST_DATA) && rx_rs_error;
  assign rs_abort  = rs_hit && !rs_error_abort_disable;
  assign last_byte = state == ST_DATA && rx_byte_valid && (byte_cnt + 10'h001 == frame_len);
  assign hdr_fail  = state == ST_HDR && rx_hdr_valid && hdr_bad;

  // Address and data capture, either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_do)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_do)
        w_held <= 1'b0;
    end
  end

  // Write response and configuration writes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid           <= 1'b0;
      s_axi_bresp            <= `RXFE_RESP_OKAY;
      rs_error_abort_disable <= `RXFE_RST_ABORT_DIS;
      rx_auto_reenable       <= `RXFE_RST_AUTO_REEN;
      fcs_seed_all_ones      <= `RXFE_RST_SEED_ONES;
      header_format_select   <= `RXFE_RST_HDR_FMT;
    end
    else
    begin
      if (wr_do)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == `RXFE_OFF_CTRL || aw_addr == `RXFE_OFF_EVENT) ?
                        `RXFE_RESP_OKAY : `RXFE_RESP_SLVERR;
        if (aw_addr == `RXFE_OFF_CTRL && w_strb[0])
        begin
          rs_error_abort_disable <= w_data[`RXFE_CTRL_ABORT_DIS];
          rx_auto_reenable       <= w_data[`RXFE_CTRL_AUTO_REEN];
          fcs_seed_all_ones      <= w_data[`RXFE_CTRL_SEED_ONES];
          header_format_select   <= w_data[`RXFE_CTRL_HDR_FMT];
        end
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Register reads
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RXFE_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RXFE_RESP_OKAY;
      case (s_axi_araddr)
        `RXFE_OFF_CTRL:
          s_axi_rdata <= {28'h0000000, header_format_select, fcs_seed_all_ones,
                          rx_auto_reenable, rs_error_abort_disable};
        `RXFE_OFF_EVENT:
          s_axi_rdata <= {28'h0000000, flag_len_err, flag_fcs_err, flag_good,
                          rx_rs_decode_error_flag};
        `RXFE_OFF_STATE:
          s_axi_rdata <= {6'h00, byte_cnt, 2'h0, frame_len, 1'b0, rx_on, state};
        `RXFE_OFF_TXFCS:
          s_axi_rdata <= {16'h0000, tx_fcs};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RXFE_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive machine next state
  always @*
  begin
    next_state = state;
    case (state)
      ST_OFF:
        if (rx_cmd_on)
          next_state = ST_HUNT;
      ST_HUNT:
        if (rx_frame_start)
          next_state = ST_HDR;
      ST_HDR:
        if (rs_abort || hdr_fail)
          next_state = rx_auto_reenable ? ST_HUNT : ST_OFF;
        else if (rx_hdr_valid)
          next_state = ST_DATA;
      ST_DATA:
        if (rs_abort)
          next_state = rx_auto_reenable ? ST_HUNT : ST_OFF;
        else if (last_byte)
          next_state = ST_OFF;
      default:
        next_state = ST_OFF;
    endcase
    if (rx_cmd_off)
      next_state = ST_OFF;
  end

  // Receive machine registers and strobes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state         <= ST_OFF;
      rx_on         <= 1'b0;
      frame_len     <= 10'h000;
      byte_cnt      <= 10'h000;
      check_pend    <= 1'b0;
      rx_hunt_start <= 1'b0;
      rx_abort      <= 1'b0;
      rx_frame_done <= 1'b0;
      rx_fcs_ok     <= 1'b0;
      tx_fcs_done   <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      rx_on         <= next_state != ST_OFF;
      rx_hunt_start <= next_state == ST_HUNT && state != ST_HUNT;
      rx_abort      <= (rs_abort || hdr_fail) && !rx_cmd_off;
      check_pend    <= last_byte && !rs_abort && !rx_cmd_off;
      rx_frame_done <= check_pend;
      rx_fcs_ok     <= check_pend && rx_crc == `RXFE_FCS_RESIDUE;
      tx_fcs_done   <= tx_byte_valid && tx_last;
      if (state == ST_HDR && rx_hdr_valid)
      begin
        frame_len <= hdr_len;
        byte_cnt  <= 10'h000;
      end
      else if (state == ST_DATA && rx_byte_valid)
        byte_cnt <= byte_cnt + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event flags, write one to clear, a new event wins
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_rs_decode_error_flag <= 1'b0;
      flag_good               <= 1'b0;
      flag_fcs_err            <= 1'b0;
      flag_len_err            <= 1'b0;
    end
    else
    begin
      if (rs_hit)
        rx_rs_decode_error_flag <= 1'b1;
      else if (ev_clr_wr && w_data[`RXFE_EV_RS_ERR])
        rx_rs_decode_error_flag <= 1'b0;
      if (check_pend && rx_crc == `RXFE_FCS_RESIDUE)
        flag_good <= 1'b1;
      else if (ev_clr_wr && w_data[`RXFE_EV_GOOD])
        flag_good <= 1'b0;
      if (check_pend && rx_crc != `RXFE_FCS_RESIDUE)
        flag_fcs_err <= 1'b1;
      else if (ev_clr_wr && w_data[`RXFE_EV_FCS_ERR])
        flag_fcs_err <= 1'b0;
      if (hdr_fail)
        flag_len_err <= 1'b1;
      else if (ev_clr_wr && w_data[`RXFE_EV_LEN_ERR])
        flag_len_err <= 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- verilog/rxfe_map.vh
// Register offsets, field positions, reset values and constants of the receive error block
`ifndef RXFE_MAP_VH
`define RXFE_MAP_VH

// Register byte offsets
`define RXFE_OFF_CTRL      4'h0
`define RXFE_OFF_EVENT     4'h4
`define RXFE_OFF_STATE     4'h8
`define RXFE_OFF_TXFCS     4'hc

// Control register field positions
`define RXFE_CTRL_ABORT_DIS   0
`define RXFE_CTRL_AUTO_REEN   1
`define RXFE_CTRL_SEED_ONES   2
`define RXFE_CTRL_HDR_FMT     3
`define RXFE_CTRL_RX_ON_CMD   8
`define RXFE_CTRL_RX_OFF_CMD  9

// Event register field positions
`define RXFE_EV_RS_ERR     0
`define RXFE_EV_GOOD       1
`define RXFE_EV_FCS_ERR    2
`define RXFE_EV_LEN_ERR    3

// Reset values of the control bits
`define RXFE_RST_ABORT_DIS 1'b0
`define RXFE_RST_AUTO_REEN 1'b0
`define RXFE_RST_SEED_ONES 1'b0
`define RXFE_RST_HDR_FMT   1'b0

// Frame check sequence constants
`define RXFE_FCS_POLY_REV  16'h8408
`define RXFE_FCS_SEED_ZERO 16'h0000
`define RXFE_FCS_SEED_ONES 16'hffff
`define RXFE_FCS_RESIDUE   16'h0000

// Payload length limits per header format
`define RXFE_STD_MAX_LEN   10'h07f
`define RXFE_EXT_MAX_LEN   10'h3ff
`define RXFE_MIN_LEN       10'h002

// Bus answers
`define RXFE_RESP_OKAY     2'b00
`define RXFE_RESP_SLVERR   2'b10

`endif

//--- verilog/rxfe_fcs.v
// Frame check sequence generator and checker, 16-bit reflected CRC
`timescale 1ns/1ps
`default_nettype none
`include "rxfe_map.vh"

module rxfe_fcs
(
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Control
  input  wire        init,
  input  wire        seed_ones,
  // Octet stream
  input  wire        byte_valid,
  input  wire [7:0]  byte_data,
  // Result
  output reg  [15:0] crc
);

  // One octet through the CRC, least significant bit first
  function [15:0] rxfe_crc_byte;
    input [15:0] c;
    input [7:0]  d;
    integer      i;
    reg   [15:0] r;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1)
      begin
        if (r[0] ^ d[i])
          r = (r >> 1) ^ `RXFE_FCS_POLY_REV;
        else
          r = r >> 1;
      end
      rxfe_crc_byte = r;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Seed load at frame start, then octet update
  always @(posedge aclk)
  begin
    if (!aresetn)
      crc <= `RXFE_FCS_SEED_ZERO;
    else if (init)
      crc <= seed_ones ? `RXFE_FCS_SEED_ONES : `RXFE_FCS_SEED_ZERO;
    else if (byte_valid)
      crc <= rxfe_crc_byte(crc, byte_data);
  end

endmodule

`default_nettype wire

//--- verilog/rxfe_hdr_check.v
// Header length field check against the selected header format
`timescale 1ns/1ps
`default_nettype none
`include "rxfe_map.vh"

module rxfe_hdr_check
(
  // Header input
  input  wire [9:0] hdr_len_raw,
  input  wire       hdr_format_ext,
  // Result
  output wire [9:0] frame_len,
  output wire       len_bad
);

  // Standard format keeps a 7-bit length field
  assign frame_len = hdr_format_ext ? hdr_len_raw : {3'h0, hdr_len_raw[6:0]};

  // Too short to hold the check sequence or above the format limit
  assign len_bad = (frame_len < `RXFE_MIN_LEN) ||
                   (frame_len > (hdr_format_ext ? `RXFE_EXT_MAX_LEN : `RXFE_STD_MAX_LEN));

endmodule

`default_nettype wire

//--- verification/rxfe_chk.sv
// Checker of abort, frame end and check sequence seeding relations
`timescale 1ns/1ps
`default_nettype none

module rxfe_chk
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus write data
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  // Receive side
  input wire logic        rx_hdr_valid,
  input wire logic        rx_rs_error,
  input wire logic        rx_on,
  input wire logic        rx_hunt_start,
  input wire logic        rx_abort,
  input wire logic        rx_frame_done,
  input wire logic        rx_fcs_ok,
  // Transmit side
  input wire logic        tx_start,
  input wire logic        tx_byte_valid,
  input wire logic        tx_last,
  input wire logic [15:0] tx_fcs,
  input wire logic        tx_fcs_done
);
  logic cfg_touched;

  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Marks any register write since reset
  always @(posedge aclk)
  begin
    if (!aresetn)
      cfg_touched <= 1'h0;
    else if (s_axi_wvalid && s_axi_wready)
      cfg_touched <= 1'h1;
  end

  ////////////////////////////////////////////////////////////
  abort_cause_a: assert property (rx_abort |-> $past(rx_rs_error) || $past(rx_hdr_valid))
    else $error("abort without a cause");
  abort_off_a: assert property (rx_abort |-> !rx_on || rx_hunt_start)
    else $error("abort left receiver on without hunt");
  hunt_on_a: assert property (rx_hunt_start |-> rx_on)
    else $error("hunt start while receiver off");
  rs_idle_a: assert property (rx_rs_error && !rx_on |=> !rx_abort)
    else $error("decode error outside frame aborted");
  done_clean_a: assert property (rx_frame_done |-> !rx_on && !rx_abort)
    else $error("frame end clashes with abort");
  fcs_pair_a: assert property (rx_fcs_ok |-> rx_frame_done)
    else $error("check ok without frame end");
  seed_value_a: assert property (tx_start && !tx_byte_valid |=>
    tx_fcs == 16'h0000 || tx_fcs == 16'hffff)
    else $error("seed not loaded at start");
  seed_reset_a: assert property (tx_start && !tx_byte_valid && !cfg_touched |=>
    tx_fcs == 16'h0000)
    else $error("seed after reset not zero");
  tx_done_a: assert property (tx_byte_valid && tx_last |=> tx_fcs_done)
    else $error("no done after last octet");

  // Main scenarios
  cover property (rx_abort && rx_hunt_start);
  cover property (rx_fcs_ok);
  cover property (tx_fcs_done);
endmodule

bind rxfe_top rxfe_chk u_chk
(
  .aclk, .aresetn, .s_axi_wvalid, .s_axi_wready, .rx_hdr_valid, .rx_rs_error, .rx_on,
  .rx_hunt_start, .rx_abort, .rx_frame_done, .rx_fcs_ok, .tx_start, .tx_byte_valid,
  .tx_last, .tx_fcs, .tx_fcs_done
);

`default_nettype wire

//--- verification/tb.sv
// Self-checking bench of the receive error and check sequence block
`timescale 1ns/1ps
`default_nettype none
`include "rxfe_map.vh"

module tb;
  typedef struct {logic [3:0] cfg; int len; int rs_at; bit bad; logic [3:0] exp; logic [3:0] ev;}
    rxfe_row_t;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, rx_frame_start, rx_hdr_valid, rx_byte_valid, rx_rs_error;
  logic        tx_start, tx_byte_valid, tx_last, rx_on, rx_hunt_start, rx_abort;
  logic        rx_frame_done, rx_fcs_ok, tx_fcs_done, s_ab, s_dn, s_ok, st_clr;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [9:0]  rx_hdr_len;
  logic [7:0]  rx_byte, tx_byte;
  logic [15:0] tx_fcs, fc;
  int          err_count, cmp_count;
  rxfe_row_t   rows [13];

  rxfe_top u_rxfe_top (.*);

  // Clock
  initial
  begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end

  // Sticky record of receive pulses, cleared before each frame
  always @(posedge aclk)
  begin
    if (st_clr)
      {s_ab, s_dn, s_ok} <= 3'h0;
    else
    begin
      if (rx_abort) s_ab <= 1'h1;
      if (rx_frame_done) s_dn <= 1'h1;
      if (rx_fcs_ok) s_ok <= 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic give_up(input bit hung);
    if (hung)
    begin
      err_count++;
      $display("unexpected at %0t: no answer", $time);
      give_verdict;
    end
  endtask

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    for (int k = 0; k < 8; k++)
      c = (c[0] ^ d[k]) ? (c >> 1) ^ `RXFE_FCS_POLY_REV : c >> 1;
    return c;
  endfunction

  // Bus write, address and data offered together
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid && n < 40);
    give_up(!s_axi_bvalid);
    chk(s_axi_bresp, r);
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask

  // Bus read
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid && n < 40);
    give_up(!s_axi_rvalid);
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask

  // One received frame, octets back to back, check sequence appended
  task automatic run_row(input rxfe_row_t r);
    logic [7:0] b;
    fc = r.cfg[2] ? 16'hffff : 16'h0000;
    axi_wr(`RXFE_OFF_EVENT, 32'hf, 2'h0);
    axi_wr(`RXFE_OFF_CTRL, {23'h0, 1'h1, 4'h0, r.cfg}, 2'h0);
    st_clr <= 1'h1;
    rx_frame_start <= 1'h1;
    @(posedge aclk);
    st_clr <= 1'h0;
    rx_frame_start <= 1'h0;
    rx_hdr_valid <= 1'h1;
    rx_hdr_len <= r.len[9:0];
    @(posedge aclk);
    rx_hdr_valid <= 1'h0;
    for (int k = 0; k < r.len; k++)
    begin
      b = (k == r.len - 1) ? fc[15:8] : (k == r.len - 2) ? fc[7:0] ^ {8{r.bad}} : 8'h30 + k[7:0];
      if (k < r.len - 2) fc = crc_step(fc, b);
      rx_byte <= b;
      rx_byte_valid <= 1'h1;
      rx_rs_error <= (k + 1 == r.rs_at);
      @(posedge aclk);
    end
    rx_byte_valid <= 1'h0;
    rx_rs_error <= 1'h0;
    repeat (4) @(posedge aclk);
    chk({s_ab, s_dn, s_ok, rx_on}, r.exp);
    axi_rd(`RXFE_OFF_EVENT, r.ev, 2'h0);
    axi_wr(`RXFE_OFF_CTRL, 32'h200, 2'h0);
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {rx_frame_start, rx_hdr_valid, rx_byte_valid, rx_rs_error, rx_hdr_len, rx_byte} = '0;
    {tx_start, tx_byte_valid, tx_last, tx_byte} = '0;
    st_clr = 1'h0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'h0;
    err_count = 0;
    cmp_count = 0;
    rows = '{'{4'h0, 6, 0, 0, 4'h6, 4'h2}, '{4'h4, 6, 0, 0, 4'h6, 4'h2},
             '{4'h0, 6, 0, 1, 4'h4, 4'h4}, '{4'h0, 6, 3, 0, 4'h8, 4'h1},
             '{4'h2, 6, 3, 0, 4'h9, 4'h1}, '{4'h1, 6, 3, 0, 4'h6, 4'h3},
             '{4'h0, 127, 0, 0, 4'h6, 4'h2}, '{4'h0, 128, 0, 0, 4'h8, 4'h8},
             '{4'h8, 128, 0, 0, 4'h6, 4'h2}, '{4'h0, 2, 0, 0, 4'h6, 4'h2},
             '{4'h0, 6, 6, 0, 4'h8, 4'h1}, '{4'h5, 6, 2, 1, 4'h4, 4'h5},
             '{4'h2, 1, 0, 0, 4'h9, 4'h8}};
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    axi_rd(`RXFE_OFF_CTRL, 32'h0, 2'h0);
    foreach (rows[j]) run_row(rows[j]);
    // Transmit check sequence with both seeds
    for (int s = 0; s < 2; s++)
    begin
      axi_wr(`RXFE_OFF_CTRL, s * 4, 2'h0);
      fc = s ? 16'hffff : 16'h0000;
      tx_start <= 1'h1;
      @(posedge aclk);
      tx_start <= 1'h0;
      for (int k = 0; k < 3; k++)
      begin
        tx_byte <= 8'ha0 + k[7:0];
        tx_byte_valid <= 1'h1;
        tx_last <= (k == 2);
        fc = crc_step(fc, 8'ha0 + k[7:0]);
        @(posedge aclk);
      end
      tx_byte_valid <= 1'h0;
      tx_last <= 1'h0;
      @(posedge aclk);
      give_up(!tx_fcs_done);
      chk(tx_fcs, fc);
      axi_rd(`RXFE_OFF_TXFCS, {16'h0000, fc}, 2'h0);
    end
    // Reset in mid-run with receiver on and all options set
    axi_wr(`RXFE_OFF_CTRL, 32'h10f, 2'h0);
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    chk(rx_on, 1'h0);
    aresetn <= 1'h1;
    @(posedge aclk);
    tx_start <= 1'h1;
    @(posedge aclk);
    tx_start <= 1'h0;
    @(posedge aclk);
    chk(tx_fcs, 16'h0000);
    axi_rd(`RXFE_OFF_CTRL, 32'h0, 2'h0);
    rx_rs_error <= 1'h1;
    @(posedge aclk);
    rx_rs_error <= 1'h0;
    repeat (2) @(posedge aclk);
    axi_rd(`RXFE_OFF_EVENT, 32'h0, 2'h0);
    axi_wr(`RXFE_OFF_STATE, 32'h1, 2'h2);
    give_verdict;
  end
endmodule

`default_nettype wire
